// ### rtl/adc_port_pkg.sv
package adc_port_pkg;

  // Output serialization modes; the lane count per channel follows from the mode.
  typedef enum logic [1:0] {LANES_1, LANES_2, LANES_4} lane_mode_t;

  // Converter word width and output lanes per channel.
  localparam int SAMPLE_BITS = 16;
  localparam int MAX_LANES = 4;

  // Serial port frame: a command byte (read flag and address), then a data byte.
  localparam int SPI_FRAME_BITS = 16;
  localparam int SPI_CMD_BITS = 8;
  localparam int SPI_ADDR_BITS = 7;

  // Mode control register addresses.
  localparam logic [6:0] REG_POWER = 7'h01;
  localparam logic [6:0] REG_TIMING = 7'h02;
  localparam logic [6:0] REG_OUTPUT = 7'h03;

  // Field positions inside the data byte.
  localparam int PWR_DOWN_BIT = 0;
  localparam int DCS_OFF_BIT = 0;
  localparam int CUR_LOW_BIT = 0;
  localparam int LANE_LSB = 1;

  // Reset values of the stored fields; the lane code selects two lanes.
  localparam logic RST_PWR_DOWN = 1'b0;
  localparam logic RST_DCS_OFF = 1'b0;
  localparam logic RST_CUR_LOW = 1'b0;
  localparam logic [1:0] RST_LANE_CODE = 2'h1;

  // Shortest bit slot the serializer accepts, in system clock cycles.
  localparam int MIN_BIT_CYCLES = 2;

  // Maps a two-bit lane code, from pins or register, onto a mode.
  function automatic lane_mode_t lane_decode(input logic [1:0] code);
    if (code == 2'h0) begin
      lane_decode = LANES_1;
    end else if (code == 2'h1) begin
      lane_decode = LANES_2;
    end else begin
      lane_decode = LANES_4;
    end
  endfunction : lane_decode

  // Number of lanes each channel uses in a mode.
  function automatic int lane_width(input lane_mode_t mode);
    case (mode)
      LANES_1: lane_width = 1;
      LANES_2: lane_width = 2;
      default: lane_width = 4;
    endcase
  endfunction : lane_width

  // Log2 of the bit slots per sample: 16, 8 or 4 slots.
  function automatic int slot_shift(input lane_mode_t mode);
    case (mode)
      LANES_1: slot_shift = 4;
      LANES_2: slot_shift = 3;
      default: slot_shift = 2;
    endcase
  endfunction : slot_shift

endpackage : adc_port_pkg

// ### rtl/sync2.sv
// Two-flop synchroniser for a bundle of independent levels.
// Bits are not coherent with each other; only use it for levels.
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);

  // First stage, read only by the second stage.
  logic [WIDTH-1:0] meta_r;

  // Both stages clear to zero under reset.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_r <= '0;
      q_out <= '0;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end

endmodule : sync2

// ### rtl/spi_mode_port.sv
// Serial programming port, clocked by the host's SCK.
// SCK only runs inside frames, so the frame logic is cleared by chip-select.
module spi_mode_port
  import adc_port_pkg::*;
(
  input wire logic spi_sck_in,
  input wire logic rst_in,
  input wire logic spi_cs_n_in,
  input wire logic strap_in,
  input wire logic spi_sdi_in,
  output logic spi_sdo_out,
  output logic spi_sdo_oe_n_out,
  output logic power_down_out,
  output logic dcs_off_out,
  output logic cur_low_out,
  output logic [1:0] lane_code_out,
  output logic wr_toggle_out
);

  logic idle; // Frame logic held clear outside a serial frame.
  logic [4:0] cnt_r; // Bits shifted so far in this frame.
  logic [SPI_FRAME_BITS-2:0] sh_r; // Bits received before the current one.
  logic [SPI_CMD_BITS-1:0] cmd; // Command byte completing at this edge.
  logic [SPI_FRAME_BITS-1:0] frame; // Whole frame completing at this edge.
  logic rd_flag_r; // This frame is a readback.
  logic [7:0] rd_byte_r; // Register contents being returned.

  // Parallel strap, chip-select high or reset all freeze the shifter.
  assign idle = rst_in | spi_cs_n_in | strap_in;
  assign cmd = {sh_r[SPI_CMD_BITS-2:0], spi_sdi_in};
  assign frame = {sh_r, spi_sdi_in};

  // The pin is open-drain: it only ever pulls low.
  assign spi_sdo_out = 1'b0;

  // Readback value of a register; unmapped addresses read zero.
  function automatic logic [7:0] reg_read(input logic [SPI_ADDR_BITS-1:0] addr);
    reg_read = 8'h00;
    if (addr == REG_POWER) begin
      reg_read[PWR_DOWN_BIT] = power_down_out;
    end else if (addr == REG_TIMING) begin
      reg_read[DCS_OFF_BIT] = dcs_off_out;
    end else if (addr == REG_OUTPUT) begin
      reg_read[CUR_LOW_BIT] = cur_low_out;
      reg_read[LANE_LSB +: 2] = lane_code_out;
    end
  endfunction : reg_read

  // Shift SDI in on each rising SCK edge while selected.
  always_ff @(posedge spi_sck_in or posedge idle) begin
    if (idle) begin
      cnt_r <= 5'h00;
      sh_r <= '0;
    end else if (cnt_r != 5'(SPI_FRAME_BITS)) begin
      // Bits beyond one frame are ignored until chip-select rises.
      cnt_r <= cnt_r + 5'h01;
      sh_r <= frame[SPI_FRAME_BITS-2:0];
    end
  end

  // Latch the read flag and the returned byte once the command is in.
  always_ff @(posedge spi_sck_in or posedge idle) begin
    if (idle) begin
      rd_flag_r <= 1'b0;
      rd_byte_r <= 8'h00;
    end else if (cnt_r == 5'(SPI_CMD_BITS - 1)) begin
      rd_flag_r <= cmd[SPI_CMD_BITS-1];
      rd_byte_r <= reg_read(cmd[SPI_ADDR_BITS-1:0]);
    end
  end

  // Mode control registers, written on the last rising edge of a write frame.
  // They survive chip-select; only the reset input clears them.
  always_ff @(posedge spi_sck_in or posedge rst_in) begin
    if (rst_in) begin
      power_down_out <= RST_PWR_DOWN;
      dcs_off_out <= RST_DCS_OFF;
      cur_low_out <= RST_CUR_LOW;
      lane_code_out <= RST_LANE_CODE;
      wr_toggle_out <= 1'b0;
    end else if (!idle && cnt_r == 5'(SPI_FRAME_BITS - 1) && !frame[SPI_FRAME_BITS-1]) begin
      if (frame[14:8] == REG_POWER) begin
        power_down_out <= frame[PWR_DOWN_BIT];
      end else if (frame[14:8] == REG_TIMING) begin
        dcs_off_out <= frame[DCS_OFF_BIT];
      end else if (frame[14:8] == REG_OUTPUT) begin
        cur_low_out <= frame[CUR_LOW_BIT];
        lane_code_out <= frame[LANE_LSB +: 2];
      end
      // The toggle tells the system side that the fields are settled.
      wr_toggle_out <= ~wr_toggle_out;
    end
  end

  // Readback bits change on falling SCK, MSB first; a one releases the pin.
  always_ff @(negedge spi_sck_in or posedge idle) begin
    if (idle) begin
      spi_sdo_oe_n_out <= 1'b1;
    end else if (rd_flag_r && cnt_r >= 5'(SPI_CMD_BITS) && cnt_r < 5'(SPI_FRAME_BITS)) begin
      spi_sdo_oe_n_out <= rd_byte_r[~cnt_r[2:0]];
    end else begin
      spi_sdo_oe_n_out <= 1'b1;
    end
  end

endmodule : spi_mode_port

// ### rtl/adc_mode_port_and_lane_select.sv
module adc_mode_port_and_lane_select
  import adc_port_pkg::*;
#(
  parameter int SAMPLE_W = SAMPLE_BITS,
  parameter int PERIOD_W = 12
) (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic rst_in,

  // Programming pins.
  input wire logic spi_sck_in,
  input wire logic programming_select_strap_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_sdi_in,
  input wire logic spi_sdo_in,
  output logic spi_sdo_out,
  output logic spi_sdo_oe_n_out,

  // Encode and samples.
  input wire logic encode_clock_pos_in,
  input wire logic encode_clock_neg_in,
  input wire logic [SAMPLE_W-1:0] ch1_sample_in,
  input wire logic [SAMPLE_W-1:0] ch2_sample_in,

  // Lanes, frame, data clock.
  output logic ch1_lane_a_out,
  output logic ch1_lane_b_out,
  output logic ch1_lane_c_out,
  output logic ch1_lane_d_out,
  output logic ch2_lane_a_out,
  output logic ch2_lane_b_out,
  output logic ch2_lane_c_out,
  output logic ch2_lane_d_out,
  output logic frame_marker_out,
  output logic forwarded_data_clock_out,

  // Mode levels.
  output logic power_down_out,
  output logic dcs_enable_out,
  output logic output_current_low_out,
  output lane_mode_t lane_mode_out
);

  // The word must split evenly over four lanes and fit the slot counters.
  if (SAMPLE_W % MAX_LANES != 0 || SAMPLE_W > 60) begin : g_bad_width
    $error("SAMPLE_W must be a multiple of four and at most 60.");
  end

  // Slot lengths are cut from the period, so it needs headroom.
  if (PERIOD_W < 6) begin : g_bad_period
    $error("PERIOD_W too small to measure a sample period.");
  end

  // Serial-port side fields, stable between write toggles.
  logic spi_pwr; // Register power-down field.
  logic spi_dcs_off; // Register stabilizer-disable field.
  logic spi_cur_low; // Register reduced-current field.
  logic [1:0] spi_lane_code; // Register lane code field.
  logic spi_wr_toggle; // Flips once per completed write frame.

  // Synchronised pin levels and the write toggle.
  logic [7:0] pins_raw;
  logic [7:0] pins_s;
  logic strap_s;
  logic cs_s;
  logic sck_s;
  logic sdi_s;
  logic sdo_s;
  logic enc_pos_s;
  logic enc_neg_s;
  logic tog_s;

  // Serial settings as captured into the system domain.
  logic tog_seen_r;
  logic cfg_pwr_r;
  logic cfg_dcs_off_r;
  logic cfg_cur_low_r;
  logic [1:0] cfg_lane_code_r;

  // Encode edge detection and sample period measurement.
  logic enc_level; // Combined encode level.
  logic enc_prev_r; // Encode level one cycle earlier.
  logic enc_rise; // Conversion start in this cycle.
  logic [PERIOD_W-1:0] period_cnt_r; // Cycles since the last encode edge.
  logic [PERIOD_W-1:0] period_r; // Last measured sample period.

  // Serializer state.
  lane_mode_t word_mode_r; // Lane mode frozen for the word in flight.
  logic active_r; // A word is being sent.
  logic [PERIOD_W-1:0] bit_len_r; // Cycles per bit slot for this word.
  logic [PERIOD_W-1:0] bit_len_nxt; // Slot length for the next word.
  logic [PERIOD_W-1:0] bit_tmr_r; // Position inside the current slot.
  logic [5:0] slot_r; // Index of the current slot.
  logic [5:0] slots; // Slots in the word in flight.
  logic [SAMPLE_W-1:0] sh1_r; // Channel 1 word, next bits on top.
  logic [SAMPLE_W-1:0] sh2_r; // Channel 2 word, next bits on top.
  logic [MAX_LANES-1:0] lane1_r; // Channel 1 lane levels, A in bit 0.
  logic [MAX_LANES-1:0] lane2_r; // Channel 2 lane levels, A in bit 0.
  logic slot_start; // A new slot begins this cycle.
  logic slot_end; // The current slot ends this cycle.

  // Pins from outside the clock domain, and the toggle, all pass two flops.
  assign pins_raw = {spi_wr_toggle, encode_clock_neg_in, encode_clock_pos_in, spi_sdo_in,
                     spi_sdi_in, spi_sck_in, spi_cs_n_in, programming_select_strap_in};
  assign {tog_s, enc_neg_s, enc_pos_s, sdo_s, sdi_s, sck_s, cs_s, strap_s} = pins_s;

  sync2 #(
    .WIDTH(8)
  ) u_pin_sync (
    .clk_in(sys_clk_in),
    .rst_in(rst_in),
    .d_in(pins_raw),
    .q_out(pins_s)
  );

  // Serial programming port on the host's clock; it frees itself under the strap.
  spi_mode_port u_spi (
    .spi_sck_in(spi_sck_in),
    .rst_in(rst_in),
    .spi_cs_n_in(spi_cs_n_in),
    .strap_in(programming_select_strap_in),
    .spi_sdi_in(spi_sdi_in),
    .spi_sdo_out(spi_sdo_out),
    .spi_sdo_oe_n_out(spi_sdo_oe_n_out),
    .power_down_out(spi_pwr),
    .dcs_off_out(spi_dcs_off),
    .cur_low_out(spi_cur_low),
    .lane_code_out(spi_lane_code),
    .wr_toggle_out(spi_wr_toggle)
  );

  // Capture the register fields once their write toggle has crossed.
  // The fields change on the same SCK edge as the toggle, which crosses two flops, so no bit is caught mid-change.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tog_seen_r <= 1'b0;
      cfg_pwr_r <= RST_PWR_DOWN;
      cfg_dcs_off_r <= RST_DCS_OFF;
      cfg_cur_low_r <= RST_CUR_LOW;
      cfg_lane_code_r <= RST_LANE_CODE;
    end else if (tog_s != tog_seen_r) begin
      // Take every field at once.
      tog_seen_r <= tog_s;
      cfg_pwr_r <= spi_pwr;
      cfg_dcs_off_r <= spi_dcs_off;
      cfg_cur_low_r <= spi_cur_low;
      cfg_lane_code_r <= spi_lane_code;
    end
  end

  // Pick the source of every mode: registers in serial, pin levels in parallel except the stabilizer, held on.
  // The strap is assumed static, so the mode source never flips during a word.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      lane_mode_out <= lane_decode(RST_LANE_CODE);
      power_down_out <= RST_PWR_DOWN;
      output_current_low_out <= RST_CUR_LOW;
      dcs_enable_out <= 1'b1;
    end else if (strap_s) begin
      // Parallel mode: chip-select is the high bit of the lane code.
      lane_mode_out <= lane_decode({cs_s, sck_s});
      // A high SDI level powers the whole part down.
      power_down_out <= sdi_s;
      // SDO as an input: low asks for the reduced drive current.
      output_current_low_out <= ~sdo_s;
      // No way to turn the stabilizer off here.
      dcs_enable_out <= 1'b1;
    end else begin
      // Serial mode: everything comes from the mode control registers.
      lane_mode_out <= lane_decode(cfg_lane_code_r);
      power_down_out <= cfg_pwr_r;
      output_current_low_out <= cfg_cur_low_r;
      dcs_enable_out <= ~cfg_dcs_off_r;
    end
  end

  // Encode is high when the true input is above the complement.
  // With the complement grounded this is plain single-ended encode.
  assign enc_level = enc_pos_s & ~enc_neg_s;
  assign enc_rise = enc_level & ~enc_prev_r;

  // Track the encode level and time the sample period between rising edges.
  // The count saturates, so a stopped encode clock gives the longest slots.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      enc_prev_r <= 1'b0;
      period_cnt_r <= '0;
      period_r <= '0;
    end else begin
      enc_prev_r <= enc_level;
      if (enc_rise) begin
        period_r <= (period_cnt_r == '1) ? period_cnt_r : period_cnt_r + PERIOD_W'(1);
        period_cnt_r <= '0;
      end else if (period_cnt_r != '1) begin
        period_cnt_r <= period_cnt_r + PERIOD_W'(1);
      end
    end
  end

  // Slot length is the sample period over 16, 8 or 4 slots, never below the floor.
  always_comb begin
    bit_len_nxt = period_r >> slot_shift(lane_mode_out);
    if (bit_len_nxt < PERIOD_W'(MIN_BIT_CYCLES)) begin
      bit_len_nxt = PERIOD_W'(MIN_BIT_CYCLES);
    end
  end

  assign slots = 6'(SAMPLE_W / lane_width(word_mode_r));
  assign slot_start = active_r && bit_tmr_r == '0;
  assign slot_end = active_r && bit_tmr_r == bit_len_r - PERIOD_W'(1);

  // Word sequencing: each encode edge restarts the serializer on a fresh word.
  // A word still in flight at the next edge is cut short, as when the slot floor stretches it past one period.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      active_r <= 1'b0;
      word_mode_r <= lane_decode(RST_LANE_CODE);
      bit_len_r <= PERIOD_W'(MIN_BIT_CYCLES);
      bit_tmr_r <= '0;
      slot_r <= '0;
    end else if (power_down_out) begin
      // Powered down: no conversions and no output activity.
      active_r <= 1'b0;
      bit_tmr_r <= '0;
      slot_r <= '0;
    end else if (enc_rise) begin
      active_r <= 1'b1;
      word_mode_r <= lane_mode_out;
      bit_len_r <= bit_len_nxt;
      bit_tmr_r <= '0;
      slot_r <= '0;
    end else if (slot_end) begin
      bit_tmr_r <= '0;
      slot_r <= slot_r + 6'h01;
      // The last slot ends the word.
      if (slot_r == slots - 6'h01) begin
        active_r <= 1'b0;
      end
    end else if (active_r) begin
      bit_tmr_r <= bit_tmr_r + PERIOD_W'(1);
    end
  end

  // Sample both channels together and shift out one lane group per slot.
  // The shift is by the lane count, so each lane takes every n-th bit, MSB first.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sh1_r <= '0;
      sh2_r <= '0;
    end else if (enc_rise && !power_down_out) begin
      sh1_r <= ch1_sample_in;
      sh2_r <= ch2_sample_in;
    end else if (slot_start) begin
      sh1_r <= sh1_r << lane_width(word_mode_r);
      sh2_r <= sh2_r << lane_width(word_mode_r);
    end
  end

  // One flop per lane; lanes past the mode's count stay low.
  for (genvar l = 0; l < MAX_LANES; l++) begin : g_lane
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
        lane1_r[l] <= 1'b0;
        lane2_r[l] <= 1'b0;
      end else if (power_down_out) begin
        lane1_r[l] <= 1'b0;
        lane2_r[l] <= 1'b0;
      end else if (slot_start) begin
        if (l < lane_width(word_mode_r)) begin
          lane1_r[l] <= sh1_r[SAMPLE_W-1-l];
          lane2_r[l] <= sh2_r[SAMPLE_W-1-l];
        end else begin
          lane1_r[l] <= 1'b0;
          lane2_r[l] <= 1'b0;
        end
      end
    end
  end

  assign ch1_lane_a_out = lane1_r[0];
  assign ch1_lane_b_out = lane1_r[1];
  assign ch1_lane_c_out = lane1_r[2];
  assign ch1_lane_d_out = lane1_r[3];
  assign ch2_lane_a_out = lane2_r[0];
  assign ch2_lane_b_out = lane2_r[1];
  assign ch2_lane_c_out = lane2_r[2];
  assign ch2_lane_d_out = lane2_r[3];

  // Frame marker is high over the first half of a word's slots.
  // It changes with the data, so the receiver finds the word start.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      frame_marker_out <= 1'b0;
    end else if (power_down_out) begin
      frame_marker_out <= 1'b0;
    end else if (enc_rise) begin
      // A one-cycle drop gives a cut-short word a fresh rising edge.
      frame_marker_out <= 1'b0;
    end else if (slot_start) begin
      frame_marker_out <= slot_r < (slots >> 1);
    end
  end

  // Data clock toggles mid-slot, one edge per bit, so both edges carry data.
  // With SAMPLE_W a multiple of eight every word has an even slot count, so the clock rests low between words.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      forwarded_data_clock_out <= 1'b0;
    end else if (power_down_out) begin
      forwarded_data_clock_out <= 1'b0;
    end else if (enc_rise) begin
      // Park low, so every word's first slot opens with a rising edge.
      forwarded_data_clock_out <= 1'b0;
    end else if (active_r && bit_tmr_r == (bit_len_r >> 1)) begin
      forwarded_data_clock_out <= ~forwarded_data_clock_out;
    end
  end

endmodule : adc_mode_port_and_lane_select

// ### sim/adc_mode_port_and_lane_select_props.sv
// Port-level checks of the mode logic and the lane output.
module adc_mode_port_and_lane_select_props
  import adc_port_pkg::*;
#(
  parameter int SAMPLE_W = SAMPLE_BITS
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic programming_select_strap_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_sck_in,
  input wire logic spi_sdi_in,
  input wire logic spi_sdo_in,
  input wire logic spi_sdo_out,
  input wire logic spi_sdo_oe_n_out,
  input wire logic encode_clock_pos_in,
  input wire logic encode_clock_neg_in,
  input wire logic [SAMPLE_W-1:0] ch1_sample_in,
  input wire logic [SAMPLE_W-1:0] ch2_sample_in,
  input wire logic ch1_lane_a_out,
  input wire logic ch1_lane_b_out,
  input wire logic ch1_lane_c_out,
  input wire logic ch1_lane_d_out,
  input wire logic ch2_lane_a_out,
  input wire logic ch2_lane_b_out,
  input wire logic ch2_lane_c_out,
  input wire logic ch2_lane_d_out,
  input wire logic frame_marker_out,
  input wire logic forwarded_data_clock_out,
  input wire logic power_down_out,
  input wire logic dcs_enable_out,
  input wire logic output_current_low_out,
  input wire lane_mode_t lane_mode_out
);
  // Everything here is checked in the system clock domain.
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  a_sdo_never_high: assert property (!spi_sdo_out && (!programming_select_strap_in || spi_sdo_oe_n_out))
    else $error("sdo driven high or pulled low in parallel mode");
  a_sdo_release_cs: assert property (spi_cs_n_in [*2] |-> spi_sdo_oe_n_out)
    else $error("sdo held low with chip-select high");
  a_par_keeps_dcs: assert property (programming_select_strap_in |-> dcs_enable_out)
    else $error("stabilizer disabled in parallel mode");
  a_par_lane_pick: assert property ((programming_select_strap_in && $stable({spi_cs_n_in, spi_sck_in})) [*6]
    |-> lane_mode_out == (spi_cs_n_in ? LANES_4 : (spi_sck_in ? LANES_2 : LANES_1)))
    else $error("parallel lane mode wrong");
  a_par_power_pin: assert property ((programming_select_strap_in && $stable(spi_sdi_in)) [*6]
    |-> power_down_out == spi_sdi_in) else $error("parallel power down wrong");
  a_par_current_pin: assert property ((programming_select_strap_in && $stable(spi_sdo_in)) [*6]
    |-> output_current_low_out == !spi_sdo_in) else $error("parallel current level wrong");
  a_power_quiet: assert property (power_down_out [*2] |-> !frame_marker_out && !forwarded_data_clock_out
    && !ch1_lane_a_out && !ch2_lane_a_out) else $error("lanes active while powered down");
  a_enc_starts_word: assert property ($rose(encode_clock_pos_in && !encode_clock_neg_in) && !power_down_out
    |-> ##[2:6] $rose(frame_marker_out)) else $error("encode edge started no word");
  a_unused_lanes: assert property ($rose(frame_marker_out) && lane_mode_out != LANES_4
    |-> !ch1_lane_c_out && !ch1_lane_d_out && !ch2_lane_c_out && !ch2_lane_d_out
    && (lane_mode_out != LANES_1 || (!ch1_lane_b_out && !ch2_lane_b_out))) else $error("unused lane active");
  a_first_bits: assert property ($rose(frame_marker_out) |-> ch1_lane_a_out == ch1_sample_in[SAMPLE_W-1]
    && ch2_lane_a_out == ch2_sample_in[SAMPLE_W-1]
    && (lane_mode_out == LANES_1 || ch2_lane_b_out == ch2_sample_in[SAMPLE_W-2])
    && (lane_mode_out != LANES_4 || ch1_lane_d_out == ch1_sample_in[SAMPLE_W-4]))
    else $error("first slot bits wrong");
endmodule : adc_mode_port_and_lane_select_props

bind adc_mode_port_and_lane_select adc_mode_port_and_lane_select_props #(.SAMPLE_W(SAMPLE_W)) props_inst (
  .sys_clk_in, .rst_in, .programming_select_strap_in, .spi_cs_n_in, .spi_sck_in, .spi_sdi_in, .spi_sdo_in,
  .spi_sdo_out, .spi_sdo_oe_n_out, .encode_clock_pos_in, .encode_clock_neg_in, .ch1_sample_in, .ch2_sample_in,
  .ch1_lane_a_out, .ch1_lane_b_out, .ch1_lane_c_out, .ch1_lane_d_out, .ch2_lane_a_out, .ch2_lane_b_out,
  .ch2_lane_c_out, .ch2_lane_d_out, .frame_marker_out, .forwarded_data_clock_out, .power_down_out, .dcs_enable_out,
  .output_current_low_out, .lane_mode_out);

// ### sim/adc_host_model.sv
// Host side of the programming port; SCK runs only inside frames, 64 ns period.
module adc_host_model (
  output logic sck_out,
  output logic cs_n_out,
  output logic sdi_out,
  input wire logic sdo_wire_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle: deselected, clock parked low.
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end

  // One frame of nbits, MSB first; a short count aborts the frame.
  task automatic frame(input logic [15:0] word, input int nbits, output logic [7:0] rd);
    rd = 8'h00;
    cs_n_out = 1'b0;
    #20;
    for (int k = 0; k < nbits; k++) begin
      sdi_out = word[15-k];
      #32 sck_out = 1'b1;
      #32;
      if (k >= 8) begin
        rd = {rd[6:0], sdo_wire_in};
      end
      sck_out = 1'b0;
    end
    #20 cs_n_out = 1'b1;
    // A released data line must not keep its last value.
    sdi_out = ~sdi_out;
    #40;
  endtask : frame
endmodule : adc_host_model

// ### sim/adc_mode_port_and_lane_select_tb_top.sv
// Bench: serial programming, readback, lane timing and parallel pins.
module adc_mode_port_and_lane_select_tb_top;
  import adc_port_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic strap = 1'b0;
  logic par_cs = 1'b0;
  logic par_sck = 1'b0;
  logic par_sdi = 1'b0;
  logic par_sdo = 1'b0;
  logic enc_run = 1'b0;
  logic enc_pos = 1'b0;
  logic [5:0] enc_cnt = 6'h00;
  logic host_sck, host_cs_n, host_sdi, sdo_out, sdo_oe_n;
  logic [7:0] lane;
  logic frame, fdc, pwr, dcs, cur;
  lane_mode_t mode;
  logic [7:0] rd;
  logic [1:0] code;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int n;
  // The SDO wire has a pull-up; in parallel mode the bench drives it as an input.
  wire sdo_pin = strap ? par_sdo : (sdo_oe_n ? 1'b1 : sdo_out);

  adc_host_model adc_host_model_inst (.sck_out(host_sck), .cs_n_out(host_cs_n), .sdi_out(host_sdi),
    .sdo_wire_in(sdo_pin));

  adc_mode_port_and_lane_select adc_mode_port_and_lane_select_inst (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .spi_sck_in(strap ? par_sck : host_sck),
    .programming_select_strap_in(strap), .spi_cs_n_in(strap ? par_cs : host_cs_n),
    .spi_sdi_in(strap ? par_sdi : host_sdi), .spi_sdo_in(sdo_pin), .spi_sdo_out(sdo_out),
    .spi_sdo_oe_n_out(sdo_oe_n), .encode_clock_pos_in(enc_pos), .encode_clock_neg_in(~enc_pos),
    .ch1_sample_in(16'ha5c3), .ch2_sample_in(16'h3c5a), .ch1_lane_a_out(lane[0]), .ch1_lane_b_out(lane[1]),
    .ch1_lane_c_out(lane[2]), .ch1_lane_d_out(lane[3]), .ch2_lane_a_out(lane[4]), .ch2_lane_b_out(lane[5]),
    .ch2_lane_c_out(lane[6]), .ch2_lane_d_out(lane[7]), .frame_marker_out(frame),
    .forwarded_data_clock_out(fdc), .power_down_out(pwr), .dcs_enable_out(dcs),
    .output_current_low_out(cur), .lane_mode_out(mode));

  always #5 sys_clk_in = ~sys_clk_in;

  // Encode clock with a 64-cycle period, so every lane mode has whole slots.
  always @(posedge sys_clk_in) begin
    enc_cnt <= enc_run ? enc_cnt + 6'h01 : 6'h00;
    enc_pos <= enc_run & ~enc_cnt[5];
  end

  // Hang guard: the whole sequence needs well under 20000 cycles.
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wait_clk(input int k);
    repeat (k) @(posedge sys_clk_in);
  endtask : wait_clk

  // Strap only moves while reset holds the part.
  task automatic do_reset(input logic s);
    rst_in <= 1'b1;
    strap <= s;
    wait_clk(6);
    rst_in <= 1'b0;
    wait_clk(2);
  endtask : do_reset

  task automatic wr(input logic [6:0] addr, input logic [7:0] data);
    adc_host_model_inst.frame({1'b0, addr, data}, 16, rd);
    wait_clk(8);
  endtask : wr

  // Length of the next high phase of frame (sel 1) or data clock (sel 0).
  task automatic hi_len(input logic sel, output int len);
    int t;
    t = 0;
    len = 0;
    while ((sel ? frame : fdc) === 1'b1 && t < 300) begin
      @(negedge sys_clk_in);
      t++;
    end
    while ((sel ? frame : fdc) !== 1'b1 && t < 300) begin
      @(negedge sys_clk_in);
      t++;
    end
    while ((sel ? frame : fdc) === 1'b1 && len < 300) begin
      @(negedge sys_clk_in);
      len++;
    end
  endtask : hi_len

  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  initial begin
    do_reset(1'b0);
    check("reset levels", {pwr, dcs, cur, 6'h00, mode}, {3'h2, 6'h00, LANES_2});
    wr(REG_POWER, 8'h01);
    check("power write", pwr, 1'b1);
    wr(REG_POWER, 8'h00);
    adc_host_model_inst.frame({1'b0, REG_POWER, 8'h01}, 12, rd);
    wait_clk(8);
    check("aborted frame", pwr, 1'b0);
    wr(7'h7f, 8'hff);
    adc_host_model_inst.frame({1'b1, 7'h7f, 8'h00}, 16, rd);
    check("unmapped read", {rd, pwr}, 9'h000);
    wr(REG_TIMING, 8'h01);
    check("stabilizer off", dcs, 1'b0);
    wr(REG_TIMING, 8'h00);
    // Each lane mode: program it, read it back, then time slots and frame.
    for (int m = 0; m < 3; m++) begin
      code = m[1:0];
      wr(REG_OUTPUT, {5'h00, code, m[0]});
      check("lane mode", {mode, cur}, {(m == 0) ? LANES_1 : ((m == 1) ? LANES_2 : LANES_4), m[0]});
      adc_host_model_inst.frame({1'b1, REG_OUTPUT, 8'h00}, 16, rd);
      check("readback", rd, {5'h00, code, m[0]});
      enc_run <= 1'b1;
      wait_clk(250);
      hi_len(1'b0, n);
      check("bit slot", n, 16'h4 << m);
      hi_len(1'b1, n);
      check("frame length", n, 16'h20);
      enc_run <= 1'b0;
      wait_clk(100);
    end
    // Parallel mode: all eight CS, SCK and SDI combinations, with SDO the inverse of SCK, set mode, power and current.
    do_reset(1'b1);
    for (int i = 0; i < 8; i++) begin
      par_cs <= i[1];
      par_sck <= i[0];
      par_sdi <= i[2];
      par_sdo <= ~i[0];
      wait_clk(8);
      check("par lanes", mode, i[1] ? LANES_4 : (i[0] ? LANES_2 : LANES_1));
      check("par power", pwr, i[2]);
      check("par current", cur, i[0]);
      check("par stabilizer", dcs, 1'b1);
    end
    complete_run();
  end
endmodule : adc_mode_port_and_lane_select_tb_top
